// [hdl/memory_map_pkg.sv]
// Shared constants and types for the startup configuration and memory-map block.
package memory_map_pkg;

	// ********************************************************
	// Register word indices (byte address is four times the index)
	// ********************************************************
	localparam logic [2:0] IDX_CONFIG = 3'h0;
	localparam logic [2:0] IDX_MAP = 3'h1;
	localparam logic [2:0] IDX_OPTIONS = 3'h2;
	localparam logic [2:0] IDX_STATUS = 3'h3;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int CFG_SEC_BIT = 3;
	localparam int CFG_WDOG_BIT = 2;
	localparam int CFG_ROM_BIT = 1;
	localparam int CFG_EEPROM_BIT = 0;
	localparam int MAP_RAM_LSB = 4;
	localparam int MAP_REG_LSB = 0;
	localparam int OPT_EDGE_IRQ_BIT = 5;
	localparam int OPT_STOP_DELAY_BIT = 4;
	localparam int OPT_RATE_LSB = 0;
	localparam logic [7:0] OPT_PROTECTED_MASK = 8'h33;
	localparam logic [7:0] OPT_FREE_MASK = 8'hC8;
	localparam int STAT_WINDOW_BIT = 0;
	localparam int STAT_MAP_DONE_BIT = 1;
	localparam int STAT_OPT_DONE_BIT = 2;
	localparam int STAT_SPECIAL_BIT = 3;
	localparam int STAT_SINGLE_BIT = 4;
	localparam int STAT_HOLD_BIT = 5;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam logic [3:0] RAM_PAGE_RESET = 4'h0;
	localparam logic [3:0] REG_PAGE_RESET = 4'h1;
	localparam logic [7:0] OPT_RESET = 8'h00;

	// ********************************************************
	// Timing counts in E-clock cycles
	// ********************************************************
	localparam logic [6:0] PROTECT_WINDOW_CYCLES = 7'h40;
	localparam logic [11:0] STOP_DELAY_CYCLES = 12'hFA0;
	localparam logic [11:0] STOP_BYPASS_CYCLES = 12'h004;

	// ********************************************************
	// Memory map
	// ********************************************************
	localparam logic [11:0] RAM_BYTES = 12'h200;
	localparam logic [11:0] REG_BLOCK_BYTES = 12'h040;
	localparam logic [15:0] ROM_FIRST = 16'hC000;
	localparam logic [15:0] ROM_LAST = 16'hFFFF;
	localparam logic [15:0] EEPROM_FIRST = 16'hB000;
	localparam logic [15:0] EEPROM_LAST = 16'hB7FF;

	// ********************************************************
	// Bus answer
	// ********************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage

// [hdl/stop_exit_delay.sv]
// Hold-off counter applied when the core leaves stop mode.
`timescale 1ns/100ps
module stop_exit_delay
	import memory_map_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic delay_enable,
	// Status
	output logic busy
);

	logic [11:0] count_ff;
	logic [11:0] nxt_count;

	// The long wait lets the crystal settle; the short one covers the restart itself.
	assign nxt_count = start ? (delay_enable ? STOP_DELAY_CYCLES : STOP_BYPASS_CYCLES)
		: ((count_ff != 12'h000) ? count_ff - 12'h001 : count_ff);
	assign busy = (count_ff != 12'h000);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			count_ff <= 12'h000;
		else
			count_ff <= nxt_count;
	end

endmodule

// [hdl/memory_map_config.sv]
// Startup configuration latches, map relocation and option protection with its bus slave.
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
// How it works
// - No security option: security-disable reads 1.
// - Watchdog-disable 1 stops watchdog, 0 runs.
// - ROM enable 0 sends ROM range external.
// - Single-chip mode forces ROM mapped.
// - EEPROM enable 0 sends EEPROM range external.
// - Map register: one write, first 64 cycles.
// - RAM field gives top address digit.
// - RAM starts at address zero after reset.
// - Register field places 64-byte block on page.
// - Register block starts at 1000 hex.
// - Protected option bits take one write.
// - Normal: 64-cycle window; special: anytime.
// - First edge after reset release copies the 4 nonvolatile bits into latches.
// - Stop exit waits 4000 cycles when enabled.
module memory_map_config
	import memory_map_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// Mode pins
	input wire logic mode_single_chip_pin,
	input wire logic mode_special_pin,
	// Nonvolatile configuration
	input wire logic security_option,
	input wire logic [3:0] nv_config,
	// Stop mode
	input wire logic stop_exit,
	output logic cpu_hold,
	// Address decode
	input wire logic [15:0] cpu_addr,
	output logic sel_regs,
	output logic sel_ram,
	output logic sel_rom,
	output logic sel_eeprom,
	output logic sel_external,
	// Configuration outputs
	output logic security_enable,
	output logic watchdog_enable,
	output logic rom_map_enable,
	output logic eeprom_map_enable,
	output logic [3:0] ram_page,
	output logic [3:0] reg_page,
	output logic irq_edge_only_select,
	output logic stop_exit_delay_enable,
	output logic [1:0] watchdog_rate_select,
	output logic protect_window_open
);

	// ********************************************************
	// Helpers
	// ********************************************************

	// True when the address falls in the first bytes of the given 4-Kbyte page.
	function automatic logic page_hit(input logic [15:0] addr, input logic [3:0] page,
		input logic [11:0] size);
		page_hit = (addr[15:12] == page) && (addr[11:0] < size);
	endfunction

	// ********************************************************
	// Declarations
	// ********************************************************
	bus_state_t bus_state_ff;
	bus_state_t nxt_bus_state;
	logic [1:0] mode_meta_ff;
	logic [1:0] mode_sync_ff;
	logic load_pending_ff;
	logic [3:0] cfg_ff;
	logic [3:0] ram_page_ff;
	logic [3:0] reg_page_ff;
	logic map_done_ff;
	logic [7:0] opt_ff;
	logic opt_done_ff;
	logic [6:0] cycle_ff;
	logic [31:0] rdata_ff;
	logic [1:0] resp_ff;
	logic single_chip;
	logic special_mode;
	logic bus_req;
	logic wr_commit;
	logic map_wr;
	logic opt_wr;
	logic map_wr_ok;
	logic opt_prot_ok;
	logic [7:0] opt_wmask;
	logic [7:0] nxt_opt;
	logic [7:0] wr_byte;
	logic [7:0] cfg_read;
	logic [7:0] map_read;
	logic [7:0] opt_read;
	logic [7:0] stat_read;
	logic [7:0] read_byte;
	logic addr_mapped;
	logic hold;
	logic hit_regs;
	logic hit_ram;
	logic hit_rom;
	logic hit_eeprom;

	// ********************************************************
	// Mode pin synchroniser
	// ********************************************************
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mode_meta_ff <= 2'h0;
			mode_sync_ff <= 2'h0;
		end
		else
		begin
			mode_meta_ff <= {mode_special_pin, mode_single_chip_pin};
			mode_sync_ff <= mode_meta_ff;
		end
	end

	assign single_chip = mode_sync_ff[0];
	assign special_mode = mode_sync_ff[1];

	// ********************************************************
	// Configuration latches
	// ********************************************************

	// The latch is loaded on the first edge after release, never by the reset itself,
	// so the 4 nonvolatile bits are sampled only once they are stable.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			load_pending_ff <= 1'b1;
			cfg_ff <= CFG_RESET;
		end
		else if (load_pending_ff)
		begin
			load_pending_ff <= 1'b0;
			cfg_ff <= nv_config;
		end
	end

	assign security_enable = security_option & ~cfg_ff[CFG_SEC_BIT];
	assign watchdog_enable = ~cfg_ff[CFG_WDOG_BIT];
	assign rom_map_enable = cfg_ff[CFG_ROM_BIT] | single_chip;
	assign eeprom_map_enable = cfg_ff[CFG_EEPROM_BIT];

	// ********************************************************
	// Protection window
	// ********************************************************
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			cycle_ff <= 7'h00;
		else if (cycle_ff < PROTECT_WINDOW_CYCLES)
			cycle_ff <= cycle_ff + 7'h01;
	end

	assign protect_window_open = (cycle_ff < PROTECT_WINDOW_CYCLES);

	// ********************************************************
	// Avalon-MM slave
	// ********************************************************

	// Every access takes exactly one wait state; read data is captured at the first edge
	// and writes land at the edge where waitrequest is low.
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & (bus_state_ff == BUS_IDLE);
	assign wr_commit = avs_write & (bus_state_ff == BUS_ANSWER) & avs_byteenable[0];
	assign wr_byte = avs_writedata[7:0];
	assign addr_mapped = (avs_address <= IDX_STATUS);

	always_comb
	begin
		nxt_bus_state = bus_state_ff;
		unique case (bus_state_ff)
			BUS_IDLE:
				if (bus_req)
					nxt_bus_state = BUS_ANSWER;
			BUS_ANSWER:
				nxt_bus_state = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			bus_state_ff <= BUS_IDLE;
			rdata_ff <= 32'h0000_0000;
			resp_ff <= RESP_OKAY;
		end
		else
		begin
			bus_state_ff <= nxt_bus_state;
			if (bus_req && (bus_state_ff == BUS_IDLE))
			begin
				rdata_ff <= {24'h00_0000, read_byte};
				resp_ff <= addr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_response = resp_ff;

	// ********************************************************
	// Read multiplexer
	// ********************************************************
	assign cfg_read = {4'h0, ~security_option | cfg_ff[CFG_SEC_BIT],
		cfg_ff[CFG_WDOG_BIT], rom_map_enable, cfg_ff[CFG_EEPROM_BIT]};
	assign map_read = {ram_page_ff, reg_page_ff};
	assign opt_read = opt_ff;
	assign stat_read = {2'h0, hold, single_chip, special_mode, opt_done_ff, map_done_ff,
		protect_window_open};
	assign read_byte = (avs_address == IDX_CONFIG) ? cfg_read
		: (avs_address == IDX_MAP) ? map_read
		: (avs_address == IDX_OPTIONS) ? opt_read
		: (avs_address == IDX_STATUS) ? stat_read
		: 8'h00;

	// ********************************************************
	// Map relocation register
	// ********************************************************
	assign map_wr = wr_commit & (avs_address == IDX_MAP);
	assign map_wr_ok = special_mode | (protect_window_open & ~map_done_ff);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ram_page_ff <= RAM_PAGE_RESET;
			reg_page_ff <= REG_PAGE_RESET;
			map_done_ff <= 1'b0;
		end
		else if (map_wr && map_wr_ok)
		begin
			ram_page_ff <= wr_byte[MAP_RAM_LSB +: 4];
			reg_page_ff <= wr_byte[MAP_REG_LSB +: 4];
			map_done_ff <= 1'b1;
		end
	end

	assign ram_page = ram_page_ff;
	assign reg_page = reg_page_ff;

	// ********************************************************
	// System options register
	// ********************************************************

	// Free bits follow every write; outside special mode the protected group is frozen after its one write.
	assign opt_wr = wr_commit & (avs_address == IDX_OPTIONS);
	assign opt_prot_ok = special_mode | (protect_window_open & ~opt_done_ff);
	assign opt_wmask = OPT_FREE_MASK | (opt_prot_ok ? OPT_PROTECTED_MASK : 8'h00);
	assign nxt_opt = (opt_ff & ~opt_wmask) | (wr_byte & opt_wmask);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			opt_ff <= OPT_RESET;
			opt_done_ff <= 1'b0;
		end
		else if (opt_wr)
		begin
			opt_ff <= nxt_opt;
			opt_done_ff <= 1'b1;
		end
	end

	assign irq_edge_only_select = opt_ff[OPT_EDGE_IRQ_BIT];
	assign stop_exit_delay_enable = opt_ff[OPT_STOP_DELAY_BIT];
	assign watchdog_rate_select = opt_ff[OPT_RATE_LSB +: 2];

	// ********************************************************
	// Stop exit hold-off
	// ********************************************************
	stop_exit_delay stop_exit_delay_inst (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(stop_exit),
		.delay_enable(stop_exit_delay_enable),
		.busy(hold)
	);

	assign cpu_hold = hold;

	// ********************************************************
	// Address decode
	// ********************************************************

	// Priority runs registers, RAM, EEPROM, ROM; anything left goes to the external bus.
	assign hit_regs = page_hit(cpu_addr, reg_page_ff, REG_BLOCK_BYTES);
	assign hit_ram = page_hit(cpu_addr, ram_page_ff, RAM_BYTES);
	assign hit_eeprom = (cpu_addr >= EEPROM_FIRST) && (cpu_addr <= EEPROM_LAST);
	assign hit_rom = (cpu_addr >= ROM_FIRST) && (cpu_addr <= ROM_LAST);

	assign sel_regs = hit_regs;
	assign sel_ram = hit_ram & ~hit_regs;
	assign sel_eeprom = hit_eeprom & eeprom_map_enable & ~hit_regs & ~hit_ram;
	assign sel_rom = hit_rom & rom_map_enable & ~hit_regs & ~hit_ram & ~sel_eeprom;
	assign sel_external = ~(sel_regs | sel_ram | sel_eeprom | sel_rom);

endmodule

// [verification/memory_map_config_sva.sv]
// Concurrent checks on the ports of the memory-map configuration block.
`timescale 1ns/100ps
module memory_map_config_sva
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bus and control inputs
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic mode_special_pin,
	input wire logic security_option,
	input wire logic stop_exit,
	input wire logic [15:0] cpu_addr,
	// Outputs watched
	input wire logic avs_waitrequest,
	input wire logic cpu_hold,
	input wire logic sel_regs,
	input wire logic sel_ram,
	input wire logic sel_rom,
	input wire logic sel_eeprom,
	input wire logic sel_external,
	input wire logic security_enable,
	input wire logic rom_map_enable,
	input wire logic eeprom_map_enable,
	input wire logic [3:0] ram_page,
	input wire logic [3:0] reg_page,
	input wire logic stop_exit_delay_enable,
	input wire logic protect_window_open
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ********************************
	// Edge counter since reset release
	// ********************************
	logic [7:0] cnt_ff;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			cnt_ff <= 8'h00;
		else if (cnt_ff != 8'hFF)
			cnt_ff <= cnt_ff + 8'h01;
	end
	// ********************************
	// Properties
	// ********************************
	property p_sec; !security_option |-> !security_enable; endproperty
	a_sec: assert property (p_sec) else $error("security on without option");
	property p_rom_off;
		(!rom_map_enable && cpu_addr[15:14] == 2'h3 && !sel_regs && !sel_ram)
			|-> (sel_external && !sel_rom);
	endproperty
	a_rom_off: assert property (p_rom_off) else $error("rom decoded while off");
	property p_eeprom_off; !eeprom_map_enable |-> !sel_eeprom; endproperty
	a_eeprom_off: assert property (p_eeprom_off) else $error("eeprom decoded while off");
	property p_regs_first;
		(cpu_addr[15:12] == reg_page && cpu_addr[11:6] == 6'h00) |-> (sel_regs && !sel_ram);
	endproperty
	a_regs_first: assert property (p_regs_first) else $error("register block not selected");
	property p_ram_page;
		(cpu_addr[15:12] == ram_page && cpu_addr[11:9] == 3'h0 && !sel_regs) |-> sel_ram;
	endproperty
	a_ram_page: assert property (p_ram_page) else $error("ram not selected");
	property p_reset_map; $fell(rst) |-> (ram_page == 4'h0 && reg_page == 4'h1); endproperty
	a_reset_map: assert property (p_reset_map) else $error("map reset value wrong");
	property p_map_frozen;
		((!mode_special_pin) [*3] ##0 (avs_write && avs_address == 3'h1 && !avs_waitrequest
			&& !protect_window_open)) |=> ($stable(ram_page) && $stable(reg_page));
	endproperty
	a_map_frozen: assert property (p_map_frozen) else $error("map changed after window");
	property p_window_open; cnt_ff < 8'h40 |-> protect_window_open; endproperty
	a_window_open: assert property (p_window_open) else $error("window shut early");
	property p_window_shut; cnt_ff >= 8'h40 |-> !protect_window_open; endproperty
	a_window_shut: assert property (p_window_shut) else $error("window open late");
	property p_stop_long; (stop_exit && stop_exit_delay_enable) |=> cpu_hold [*8]; endproperty
	a_stop_long: assert property (p_stop_long) else $error("long hold missing");
	property p_stop_short;
		(stop_exit && !stop_exit_delay_enable) |=> cpu_hold [*4] ##1 !cpu_hold;
	endproperty
	a_stop_short: assert property (p_stop_short) else $error("short hold wrong");
	c_stop: cover property (stop_exit);
	c_unmapped: cover property (avs_read && !avs_waitrequest && avs_address[2]);
	c_late_write: cover property (avs_write && !avs_waitrequest && !protect_window_open);
endmodule
bind memory_map_config memory_map_config_sva memory_map_config_sva_inst (.clk_sys, .rst,
	.avs_address, .avs_read, .avs_write, .mode_special_pin, .security_option, .stop_exit,
	.cpu_addr, .avs_waitrequest, .cpu_hold, .sel_regs, .sel_ram, .sel_rom, .sel_eeprom,
	.sel_external, .security_enable, .rom_map_enable, .eeprom_map_enable, .ram_page,
	.reg_page, .stop_exit_delay_enable, .protect_window_open);

// [verification/memory_map_config_test.sv]
// Self-checking bench for the memory-map configuration block.
`timescale 1ns/100ps
module memory_map_config_test
	import memory_map_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic mode_single_chip_pin = 1'b0;
	logic mode_special_pin = 1'b0;
	logic security_option = 1'b1;
	logic [3:0] nv_config = 4'hC;
	logic stop_exit = 1'b0;
	logic [15:0] cpu_addr = 16'h0000;
	logic [31:0] avs_readdata;
	logic [1:0] avs_response;
	logic [1:0] resp_seen;
	logic avs_waitrequest, cpu_hold, sel_regs, sel_ram, sel_rom, sel_eeprom, sel_external;
	logic security_enable, watchdog_enable, rom_map_enable, eeprom_map_enable;
	logic irq_edge_only_select, stop_exit_delay_enable, protect_window_open;
	logic [3:0] ram_page, reg_page;
	logic [1:0] watchdog_rate_select;
	int num_errors = 0;
	int total_checks = 0;
	memory_map_config memory_map_config_inst (.clk_sys, .rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
		.avs_response, .mode_single_chip_pin, .mode_special_pin, .security_option,
		.nv_config, .stop_exit, .cpu_hold, .cpu_addr, .sel_regs, .sel_ram, .sel_rom,
		.sel_eeprom, .sel_external, .security_enable, .watchdog_enable, .rom_map_enable,
		.eeprom_map_enable, .ram_page, .reg_page, .irq_edge_only_select,
		.stop_exit_delay_enable, .watchdog_rate_select, .protect_window_open);
	always #50 clk_sys = ~clk_sys;
	// ********************************
	// Shared tasks
	// ********************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// The request stands until waitrequest is seen low at a rising edge; only the watchdog
	// ends a wait that never finishes.
	task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		q = avs_readdata;
		resp_seen = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(what, {24'h000000, exp}, q);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic dec(input logic [15:0] a, input logic [4:0] exp);
		@(posedge clk_sys);
		cpu_addr <= a;
		@(negedge clk_sys);
		chk("decode", {27'h0, exp}, {27'h0, sel_regs, sel_ram, sel_rom, sel_eeprom, sel_external});
	endtask
	task automatic stop(input int len);
		int n;
		@(posedge clk_sys);
		stop_exit <= 1'b1;
		@(posedge clk_sys);
		stop_exit <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end
		while (cpu_hold === 1'b1 && n < 5000);
		chk("hold cycles", 32'(len), 32'(n - 1));
	endtask
	task automatic restart(input logic spec, input logic single, input logic opt,
		input logic [3:0] nv);
		@(posedge clk_sys);
		rst <= 1'b1;
		mode_special_pin <= spec;
		mode_single_chip_pin <= single;
		security_option <= opt;
		nv_config <= nv;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task automatic t_normal;
		restart(1'b0, 1'b0, 1'b1, 4'hC);
		rd(IDX_CONFIG, 8'h0C, "config");
		rd(IDX_MAP, 8'h01, "map reset");
		chk("response okay", {30'h0, RESP_OKAY}, {30'h0, resp_seen});
		chk("security", 32'h0, {31'h0, security_enable});
		chk("watchdog", 32'h0, {31'h0, watchdog_enable});
		dec(16'h1000, 5'h10);
		dec(16'h0000, 5'h08);
		dec(16'hB000, 5'h01);
		dec(16'hC000, 5'h01);
		wr(IDX_MAP, 8'h32);
		wr(IDX_MAP, 8'h45);
		rd(IDX_MAP, 8'h32, "map once");
		dec(16'h2000, 5'h10);
		dec(16'h31FF, 5'h08);
		wr(IDX_OPTIONS, 8'hFF);
		rd(IDX_OPTIONS, 8'hFB, "options first");
		wr(IDX_OPTIONS, 8'h00);
		rd(IDX_OPTIONS, 8'h33, "options once");
		chk("option outputs", 32'hF, {28'h0, irq_edge_only_select, stop_exit_delay_enable,
			watchdog_rate_select});
		$display("test normal mode done");
	endtask
	task automatic t_late;
		repeat (40) @(posedge clk_sys);
		chk("window", 32'h0, {31'h0, protect_window_open});
		rd(IDX_STATUS, 8'h06, "status");
		wr(IDX_MAP, 8'h77);
		rd(IDX_MAP, 8'h32, "map frozen");
		rd(3'h5, 8'h00, "unmapped");
		chk("response", {30'h0, RESP_SLVERR}, {30'h0, resp_seen});
		stop(4000);
		$display("test late writes done");
	endtask
	task automatic t_special;
		restart(1'b1, 1'b1, 1'b0, 4'h1);
		rd(IDX_CONFIG, 8'h0B, "config special");
		chk("watchdog", 32'h1, {31'h0, watchdog_enable});
		repeat (70) @(posedge clk_sys);
		wr(IDX_MAP, 8'h66);
		wr(IDX_MAP, 8'h55);
		rd(IDX_MAP, 8'h55, "map special");
		wr(IDX_OPTIONS, 8'h11);
		wr(IDX_OPTIONS, 8'h22);
		rd(IDX_OPTIONS, 8'h22, "options special");
		chk("option outputs", 32'hA, {28'h0, irq_edge_only_select, stop_exit_delay_enable,
			watchdog_rate_select});
		dec(16'h5000, 5'h10);
		dec(16'h5040, 5'h08);
		dec(16'hB000, 5'h02);
		dec(16'hC000, 5'h04);
		stop(4);
		$display("test special mode done");
	endtask
	initial
	begin
		t_normal();
		t_late();
		t_special();
		stop_test();
	end
	// The run needs about 4200 cycles; the limit allows nearly five times that.
	initial
	begin
		#2000000;
		num_errors++;
		stop_test();
	end
endmodule
